// ===== rbc_ctrl.v
// Reset and boot configuration controller of a three-port switch.
// Assumes an APB master on pclk, a 100 MHz pclk derived from the single
// reference clock, and power-on reset on presetn.
//
// Behaviour
// - One 100 MHz reference clocks everything; all logic here runs on pclk.
// - Straps are captured when the fundamental reset input is released.
// - Strap changes at any other time are ignored.
// - Captured straps stay readable in the switch status register.
// - Overridable straps may be replaced by EEPROM or SMBus during reset.
// - Downstream common-clock strap loads every downstream slot clock bit.
// - Upstream common-clock strap loads the upstream slot clock bit.
// - Slow strap selects 100 KHz master bus, else 400 KHz; no override.
// - Reset input assertion resets logic and starts a fundamental reset.
// - Halt strap keeps device in reset after procedure, buses alive.
// - Halted device leaves reset only when halt bit is cleared.
// - Mode strap: 0 normal, 1 normal with EEPROM, 2 to 7 reserved.
// - Fundamental reset returns every register field to initial state; the trigger-bit reset keeps the secondary bus reset bits.
// - Hot reset resets logic but keeps sticky fields.
// - Upstream secondary bus reset hot resets all but upstream bridge.
// - Downstream secondary bus reset propagates hot reset on its link.
// - Writing one to the trigger bit starts a warm fundamental reset.
// - Reset input with power kept is warm; after power-on it is cold.
// - EEPROM may modify any bit of any software-visible register; here not the status register, and slot clock bits are reloaded after it.
// - Reset without the input reuses previously captured straps.
// - Trigger write completes successfully before warm reset starts.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`default_nettype none
`include "rbc_consts.vh"

module rbc_ctrl #(
    parameter NDS      = 2,
    parameter STEP_CYC = `RBC_RST_STEP_CYC,
    parameter HOT_CYC  = `RBC_HOT_CYC
) (
    input  wire            pclk,
    input  wire            presetn,
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [11:0]     paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output reg             pready,
    output reg             pslverr,
    input  wire            fund_reset_in_n,
    input  wire            common_clk_downstream_strap,
    input  wire            common_clk_upstream_strap,
    input  wire            master_mgmt_bus_slow_strap,
    input  wire            reset_halt,
    input  wire [2:0]      switch_mode_strap,
    input  wire            ee_wr_valid,
    input  wire [11:0]     ee_wr_addr,
    input  wire [31:0]     ee_wr_data,
    input  wire            upstream_hot_req,
    output reg             core_reset_n,
    output reg             sticky_reset_n,
    output reg             upstream_bridge_reset_n,
    output reg  [NDS-1:0]  vbus_hot_reset,
    output reg  [NDS-1:0]  ds_link_hot_reset,
    output reg             mgmt_bus_slow,
    output reg             ee_init_en,
    output reg             mode_reserved
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisation

wire       perst_s;
wire [6:0] straps_s;

rbc_sync3 #(.W(1), .RST(0)) u_sync_perst (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (fund_reset_in_n),
    .dout    (perst_s)
);

rbc_sync3 #(.W(7), .RST(0)) u_sync_straps (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({switch_mode_strap, reset_halt, master_mgmt_bus_slow_strap,
                common_clk_upstream_strap, common_clk_downstream_strap}),
    .dout    (straps_s)
);

////////////////////////////////////////////////////////////////////////////////
// Sequencer

localparam S_IN_RESET = 3'h0;
localparam S_STEP     = 3'h1;
localparam S_HALT     = 3'h2;
localparam S_RUN      = 3'h3;
localparam S_HOT      = 3'h4;

reg [2:0]  state_r;
reg [15:0] cnt_r;
reg        perst_d_r;
reg        powered_r;
reg        cold_r;
reg        warm_r;
reg [6:0]  cap_r;
reg        fund_reset_trigger_bit_pend_r;
reg        halt_bit_r;
reg        usbr_r;
reg [NDS-1:0] dsbr_r;
reg [8:0]  ovr_r;
reg        sclk_us_r;
reg [NDS-1:0] sclk_ds_r;
reg        load_sclk_r;
reg [31:0] sticky_r;

wire perst_rise = perst_s & ~perst_d_r;
wire perst_low  = ~perst_s;

// Effective straps after the optional override during fundamental reset
wire [2:0] eff_mode = ovr_r[`RBC_OVR_EN] ?
                      ovr_r[`RBC_OVR_MODE_LO+2:`RBC_OVR_MODE_LO] : cap_r[6:4];
wire       eff_halt = ovr_r[`RBC_OVR_EN] ? ovr_r[`RBC_OVR_HALT] : cap_r[3];
wire       eff_ccus = ovr_r[`RBC_OVR_EN] ? ovr_r[`RBC_OVR_CCUS] : cap_r[1];
wire       eff_ccds = ovr_r[`RBC_OVR_EN] ? ovr_r[`RBC_OVR_CCDS] : cap_r[0];

////////////////////////////////////////////////////////////////////////////////
// APB decode

wire apb_acc  = psel & penable & pready;
wire apb_wr   = apb_acc & pwrite;
wire in_fund  = (state_r == S_IN_RESET) | (state_r == S_STEP);

function is_mapped;
    input [11:0] a;
    begin
        is_mapped = (a == `RBC_OFS_CTRL) | (a == `RBC_OFS_STAT) |
                    (a == `RBC_OFS_USLSTS) | (a == `RBC_OFS_DSLSTS) |
                    (a == `RBC_OFS_RSTCTL) | (a == `RBC_OFS_OVR) |
                    (a == `RBC_OFS_EEWR);
    end
endfunction

// A single write port shared by software and the EEPROM loader
wire        wr_en   = apb_wr | (ee_wr_valid & ee_init_en);
wire [11:0] wr_addr = apb_wr ? paddr  : ee_wr_addr;
wire [31:0] wr_data = apb_wr ? pwdata : ee_wr_data;

wire [31:0] status_word = {19'h0, (eff_mode > `RBC_MODE_EEPROM),
                           state_r == S_HALT, ~core_reset_n, warm_r, cold_r,
                           1'b0, cap_r[6:4], cap_r[3], cap_r[2], cap_r[1], cap_r[0]};

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0;
    end
    else
    begin
        // One wait state: answer in the second access cycle
        pready  <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & ~is_mapped(paddr);
        if (psel & penable & ~pready & ~pwrite)
        begin
            case (paddr)
                `RBC_OFS_CTRL:   prdata <= {29'h0, halt_bit_r, 2'h0};
                `RBC_OFS_STAT:   prdata <= status_word;
                `RBC_OFS_USLSTS: prdata <= {19'h0, sclk_us_r, 12'h0};
                `RBC_OFS_DSLSTS: prdata <= {{(32-NDS){1'b0}}, sclk_ds_r};
                `RBC_OFS_RSTCTL: prdata <= {{(31-NDS){1'b0}}, dsbr_r, usbr_r};
                `RBC_OFS_OVR:    prdata <= {23'h0, ovr_r};
                `RBC_OFS_EEWR:   prdata <= sticky_r;
                default:         prdata <= 32'h0;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Strap capture and reset classification

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        perst_d_r <= 1'b0;
        powered_r <= 1'b0;
        cold_r    <= 1'b0;
        warm_r    <= 1'b0;
        cap_r     <= 7'h0;
    end
    else
    begin
        perst_d_r <= perst_s;
        if (perst_rise)
        begin
            cap_r     <= straps_s;
            powered_r <= 1'b1;
            cold_r    <= ~powered_r;
            warm_r    <= powered_r;
        end
        else if (state_r == S_RUN && fund_reset_trigger_bit_pend_r)
        begin
            cold_r <= 1'b0;
            warm_r <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Reset state machine

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_r      <= S_IN_RESET;
        cnt_r        <= 16'h0;
        fund_reset_trigger_bit_pend_r  <= 1'b0;
        halt_bit_r   <= 1'b0;
        usbr_r       <= 1'b0;
        dsbr_r       <= {NDS{1'b0}};
        ovr_r        <= 9'h0;
        load_sclk_r  <= 1'b0;
    end
    else
    begin
        load_sclk_r <= 1'b0;
        if (perst_low)
        begin
            state_r     <= S_IN_RESET;
            fund_reset_trigger_bit_pend_r <= 1'b0;
            halt_bit_r  <= 1'b0;
            usbr_r      <= 1'b0;
            dsbr_r      <= {NDS{1'b0}};
            ovr_r       <= 9'h0;
        end
        else
        begin
            if (wr_en && wr_addr == `RBC_OFS_CTRL)
            begin
                if (wr_data[`RBC_CTL_FUND])
                    fund_reset_trigger_bit_pend_r <= 1'b1;
                if (!wr_data[`RBC_CTL_HALT])
                    halt_bit_r <= 1'b0;
                else if (in_fund)
                    halt_bit_r <= 1'b1;
            end
            if (wr_en && wr_addr == `RBC_OFS_RSTCTL)
            begin
                usbr_r <= wr_data[`RBC_RC_USBR];
                dsbr_r <= wr_data[`RBC_RC_DSBR_LO+NDS-1:`RBC_RC_DSBR_LO];
            end
            if (wr_en && wr_addr == `RBC_OFS_OVR && in_fund)
                ovr_r <= wr_data[8:0];
            case (state_r)
                S_IN_RESET:
                begin
                    state_r <= S_STEP;
                    cnt_r   <= STEP_CYC[15:0];
                    halt_bit_r <= perst_rise ? straps_s[3] : eff_halt;
                end
                S_STEP:
                begin
                    if (cnt_r > 16'h1)
                        cnt_r <= cnt_r - 16'h1;
                    else
                    begin
                        load_sclk_r <= 1'b1;
                        state_r <= halt_bit_r ? S_HALT : S_RUN;
                    end
                end
                S_HALT:
                begin
                    if (!halt_bit_r)
                        state_r <= S_RUN;
                end
                S_RUN:
                begin
                    // The answer of the trigger write has gone out already
                    if (fund_reset_trigger_bit_pend_r && !pready)
                    begin
                        fund_reset_trigger_bit_pend_r <= 1'b0;
                        state_r     <= S_IN_RESET;
                        halt_bit_r  <= 1'b0;
                        ovr_r       <= 9'h0;
                    end
                    else if (upstream_hot_req || (wr_en && wr_addr == `RBC_OFS_CTRL &&
                             wr_data[`RBC_CTL_HRST]))
                    begin
                        state_r <= S_HOT;
                        cnt_r   <= HOT_CYC[15:0];
                    end
                end
                S_HOT:
                begin
                    if (cnt_r > 16'h1)
                        cnt_r <= cnt_r - 16'h1;
                    else
                        state_r <= S_RUN;
                end
                default: state_r <= S_IN_RESET;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Slot clock bits, sticky scratch and outputs

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sclk_us_r <= 1'b0;
        sclk_ds_r <= {NDS{1'b0}};
        sticky_r  <= 32'h0;
    end
    else
    begin
        if (load_sclk_r)
        begin
            sclk_us_r <= eff_ccus;
            sclk_ds_r <= {NDS{eff_ccds}};
        end
        else
        begin
            if (wr_en && wr_addr == `RBC_OFS_USLSTS)
                sclk_us_r <= wr_data[`RBC_LS_SCLK];
            if (wr_en && wr_addr == `RBC_OFS_DSLSTS)
                sclk_ds_r <= wr_data[NDS-1:0];
        end
        // Sticky scratch survives hot reset; cleared only by fundamental reset
        if (perst_low || (state_r == S_RUN && fund_reset_trigger_bit_pend_r && !pready))
            sticky_r <= 32'h0;
        else if (wr_en && wr_addr == `RBC_OFS_EEWR)
            sticky_r <= wr_data;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        core_reset_n            <= 1'b0;
        sticky_reset_n          <= 1'b0;
        upstream_bridge_reset_n <= 1'b0;
        vbus_hot_reset          <= {NDS{1'b0}};
        ds_link_hot_reset       <= {NDS{1'b0}};
        mgmt_bus_slow           <= 1'b0;
        ee_init_en              <= 1'b0;
        mode_reserved           <= 1'b0;
    end
    else
    begin
        core_reset_n            <= (state_r == S_RUN);
        sticky_reset_n          <= ~in_fund;
        upstream_bridge_reset_n <= (state_r == S_RUN);
        vbus_hot_reset          <= {NDS{usbr_r | (state_r == S_HOT)}};
        ds_link_hot_reset       <= dsbr_r | {NDS{state_r == S_HOT}};
        mgmt_bus_slow           <= cap_r[2];
        ee_init_en              <= (state_r == S_STEP) &&
                                   (eff_mode == `RBC_MODE_EEPROM);
        mode_reserved           <= (eff_mode > `RBC_MODE_EEPROM);
    end
end

endmodule // rbc_ctrl

`default_nettype wire

// ===== rbc_consts.vh
// Constants for the reset and boot configuration controller.
// Assumes inclusion by bare name from the design files.
`ifndef RBC_CONSTS_VH
`define RBC_CONSTS_VH

// Register byte offsets
`define RBC_OFS_CTRL       12'h000
`define RBC_OFS_STAT       12'h004
`define RBC_OFS_USLSTS     12'h008
`define RBC_OFS_DSLSTS     12'h00c
`define RBC_OFS_RSTCTL     12'h010
`define RBC_OFS_OVR        12'h014
`define RBC_OFS_EEWR       12'h018

// Control register fields
`define RBC_CTL_FUND       0
`define RBC_CTL_HRST       1
`define RBC_CTL_HALT       2

// Status register fields
`define RBC_STS_CCDS       0
`define RBC_STS_CCUS       1
`define RBC_STS_SLOW       2
`define RBC_STS_HALT       3
`define RBC_STS_MODE_LO    4
`define RBC_STS_MODE_HI    6
`define RBC_STS_COLD       8
`define RBC_STS_WARM       9
`define RBC_STS_INRST      10
`define RBC_STS_HALTED     11
`define RBC_STS_MODE_RSVD  12

// Secondary bus reset control fields
`define RBC_RC_USBR        0
`define RBC_RC_DSBR_LO     1

// Override register fields
`define RBC_OVR_CCDS       0
`define RBC_OVR_CCUS       1
`define RBC_OVR_HALT       2
`define RBC_OVR_MODE_LO    4
`define RBC_OVR_EN         8

// Link status slot clock bit
`define RBC_LS_SCLK        12

// Switch modes
`define RBC_MODE_NORMAL    3'h0
`define RBC_MODE_EEPROM    3'h1

// Timing
`define RBC_CLK_MHZ        100
`define RBC_RST_STEP_NS    200
`define RBC_RST_STEP_CYC   ((`RBC_RST_STEP_NS * `RBC_CLK_MHZ + 999) / 1000)
`define RBC_HOT_NS         100
`define RBC_HOT_CYC        ((`RBC_HOT_NS * `RBC_CLK_MHZ + 999) / 1000)

`endif

// ===== rbc_sync3.v
// Three-flop synchroniser with agreement filter for strap and reset pins.
// Assumes inputs are asynchronous to pclk.
`default_nettype none

module rbc_sync3 #(
    parameter W   = 1,
    parameter RST = 0
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);

reg [W-1:0] s1_r;
reg [W-1:0] s2_r;
reg [W-1:0] s3_r;

// A change counts only once the second and third flops agree
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        s1_r <= {W{RST[0]}};
        s2_r <= {W{RST[0]}};
        s3_r <= {W{RST[0]}};
        dout <= {W{RST[0]}};
    end
    else
    begin
        s1_r <= din;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r)
            dout <= s3_r;
    end
end

endmodule // rbc_sync3

`default_nettype wire

// ===== rbc_ctrl_properties.sv
// Checker for the controller's bus timing and reset outputs.
// Assumes it is bound onto rbc_ctrl and sees only its ports.
`default_nettype none
`include "rbc_consts.vh"
module rbc_ctrl_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fund_reset_in_n,
    input wire logic        core_reset_n,
    input wire logic        sticky_reset_n,
    input wire logic        upstream_bridge_reset_n,
    input wire logic        mgmt_bus_slow,
    input wire logic        ee_init_en,
    input wire logic        mode_reserved
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence one_wait_s;
        !pready ##1 pready;
    endsequence
    sequence trig_ack_s;
        pready && pwrite && paddr == `RBC_OFS_CTRL && pwdata[`RBC_CTL_FUND] && core_reset_n;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    wait_state_a: assert property (setup_s ##1 psel && penable |-> one_wait_s)
        else $error("pready not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    pin_reset_a: assert property (!fund_reset_in_n [*7] |-> !core_reset_n && !sticky_reset_n)
        else $error("pin low but logic not in reset");
    slow_held_a: assert property (core_reset_n && $past(core_reset_n) |-> $stable(mgmt_bus_slow))
        else $error("bus speed moved while running");
    mode_held_a: assert property (core_reset_n && $past(core_reset_n) |-> $stable(mode_reserved))
        else $error("mode flag moved while running");
    ee_in_reset_a: assert property (ee_init_en |-> !core_reset_n)
        else $error("loader enabled while running");
    bridge_run_a: assert property (core_reset_n |-> upstream_bridge_reset_n)
        else $error("bridge held in reset while running");
    trig_after_ack_a: assert property (trig_ack_s |-> ##[1:16] !core_reset_n)
        else $error("trigger write did not reset after ack");
endmodule // rbc_ctrl_props
bind rbc_ctrl rbc_ctrl_props rbc_ctrl_props_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .fund_reset_in_n, .core_reset_n, .sticky_reset_n,
    .upstream_bridge_reset_n, .mgmt_bus_slow, .ee_init_en, .mode_reserved);
`default_nettype wire

// ===== rbc_sys_model.sv
// System reset source: drives the reset pin and the strap vector.
// Assumes the bench calls its tasks right after a rising pclk edge.
`default_nettype none
module rbc_sys_model (
    input  wire logic       pclk,
    output var  logic       rst_n,
    output var  logic [6:0] straps
);
    timeunit 1ns;
    timeprecision 1ps;
    // Power comes up with the pin held low, so the first release is the cold one
    initial
    begin
        rst_n = 1'b0;
        straps = 7'h00;
    end
    // Straps settle while the pin is low and stay static after release
    task automatic fund_reset(input logic [6:0] s);
        rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        straps <= s;
        repeat (6) @(posedge pclk);
        rst_n <= 1'b1;
    endtask
    // Late strap change, which the device has to ignore
    task automatic wiggle(input logic [6:0] s);
        straps <= s;
        @(posedge pclk);
    endtask
endmodule // rbc_sys_model
`default_nettype wire

// ===== reset_boot_config_control_tb_top.sv
// Self-checking bench for the reset and boot configuration controller.
// Assumes rbc_ctrl with NDS=2, STEP_CYC=20 and the offsets of rbc_consts.vh.
`default_nettype none
`include "rbc_consts.vh"
module reset_boot_config_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] e; logic [31:0] m; logic er;} rbc_exp_t;
    localparam logic [11:0] CTL = `RBC_OFS_CTRL;
    localparam logic [11:0] STS = `RBC_OFS_STAT;
    localparam logic [11:0] SCR = `RBC_OFS_EEWR;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ee_v, core_n, st_n, br_n;
    logic slow, ee_en, rsv, rst_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [6:0] straps, s;
    logic [1:0] vbus, dsl;
    rbc_exp_t q[$];
    rbc_exp_t x;
    int n_errors = 0;
    int num_checks = 0;
    int i, k;
    rbc_ctrl rbc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fund_reset_in_n(rst_n), .common_clk_downstream_strap(straps[0]),
        .common_clk_upstream_strap(straps[1]), .master_mgmt_bus_slow_strap(straps[2]),
        .reset_halt(straps[3]), .switch_mode_strap(straps[6:4]), .ee_wr_valid(ee_v),
        .ee_wr_addr(SCR), .ee_wr_data(r), .upstream_hot_req(1'b0), .core_reset_n(core_n),
        .sticky_reset_n(st_n), .upstream_bridge_reset_n(br_n), .vbus_hot_reset(vbus),
        .ds_link_hot_reset(dsl), .mgmt_bus_slow(slow), .ee_init_en(ee_en),
        .mode_reserved(rsv));
    rbc_sys_model rbc_sys_model_inst (.pclk(pclk), .rst_n(rst_n), .straps(straps));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    // Every transfer leaves a note, so a stray pready is caught too
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic [31:0] m, input logic er);
        q.push_back('{e, m, er});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: a stalled slave is ended by the watchdog only
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_core(input logic lvl);
        k = 0;
        while (core_n !== lvl && k < 200)
        begin
            @(posedge pclk);
            k++;
        end
        chk(core_n, lvl);
    endtask
    function automatic logic [31:0] sts(input logic [6:0] v, input logic c);
        return {19'h0, v[6:4] > 3'h1, 2'b00, !c, c, 1'b0, v};
    endfunction
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
        if (pready === 1'b1)
        begin
            x = (q.size() > 0) ? q.pop_front() : '{32'h1, 32'h1, 1'b0};
            chk(prdata & x.m, x.e);
            chk({31'h0, pslverr}, {31'h0, x.er});
        end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, ee_v, paddr, pwdata} = '0;
        void'($urandom(3324));
        r = $urandom;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            s = {i[2:0], 1'b0, 3'($urandom)};
            rbc_ctrl_inst_reset(s);
            if (i == 1)
            begin
                k = 0;
                while (ee_en !== 1'b1 && k < 100) begin @(posedge pclk); k++; end
                chk({31'h0, ee_en}, 32'h1);
                ee_v <= 1'b1;
                @(posedge pclk);
                ee_v <= 1'b0;
            end
            wait_core(1'b1);
            apb(0, STS, 0, sts(s, i == 0), 32'h1f7f, 0);
            apb(0, `RBC_OFS_USLSTS, 0, {19'h0, s[1], 12'h0}, 32'h1000, 0);
            apb(0, `RBC_OFS_DSLSTS, 0, {30'h0, {2{s[0]}}}, 32'h3, 0);
            apb(0, SCR, 0, (i == 1) ? r : 32'h0, '1, 0);
            chk({rsv, slow}, {30'h0, i > 1, s[2]});
        end
        rbc_sys_model_inst.wiggle(~s);
        apb(0, STS, 0, sts(s, 0), 32'h1f7f, 0);
        apb(1, `RBC_OFS_DSLSTS, {30'h0, ~{2{s[0]}}}, 0, 0, 0);
        apb(0, `RBC_OFS_DSLSTS, 0, {30'h0, ~{2{s[0]}}}, 32'h3, 0);
        apb(0, 12'h01c, 0, 0, '1, 1);
        apb(1, SCR, r, 0, 0, 0);
        apb(1, CTL, 32'h1, 0, 0, 0);
        wait_core(1'b0);
        wait_core(1'b1);
        apb(0, STS, 0, sts(s, 0), 32'h1f7f, 0);
        apb(0, SCR, 0, 0, '1, 0);
        apb(1, SCR, ~r, 0, 0, 0);
        apb(1, CTL, 32'h2, 0, 0, 0);
        wait_core(1'b0);
        wait_core(1'b1);
        apb(0, SCR, 0, ~r, '1, 0);
        apb(1, `RBC_OFS_RSTCTL, 32'h1, 0, 0, 0);
        // The reset outputs follow the control bits one clock later
        @(posedge pclk);
        chk({29'h0, vbus, br_n}, 32'h7);
        apb(1, `RBC_OFS_RSTCTL, 32'h2, 0, 0, 0);
        @(posedge pclk);
        chk({30'h0, dsl}, 32'h1);
        apb(1, `RBC_OFS_RSTCTL, 32'h0, 0, 0, 0);
        rbc_ctrl_inst_reset(7'h08);
        repeat (40) @(posedge pclk);
        chk({31'h0, core_n}, 32'h0);
        apb(0, STS, 0, 32'h0808, 32'h0808, 0);
        apb(0, CTL, 0, 32'h4, '1, 0);
        apb(1, CTL, 32'h0, 0, 0, 0);
        wait_core(1'b1);
        wrap_up();
    end
    task automatic rbc_ctrl_inst_reset(input logic [6:0] v);
        rbc_sys_model_inst.fund_reset(v);
    endtask
endmodule // reset_boot_config_control_tb_top
`default_nettype wire
